// ### rtl/dso_pkg.sv
package dso_pkg;
  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int SHORT_W = 12; // Short unsigned type width
  localparam int LONG_W = 32; // Long unsigned type width
  typedef logic [SHORT_W-1:0] dso_short_t;
  typedef logic [LONG_W-1:0] dso_long_t;
  localparam int ADDR_W = 4;
  localparam int VOL_W = 32;

  // ==========================================================================
  // Register map (word offsets as byte addresses)
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_VERSION = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_PURGE = 4'hc;

  // Control register fields
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_FP_ALARM = 1;
  localparam int CTRL_SYS_ALARM = 2;
  localparam int CTRL_DEVIATION = 3;
  localparam int CTRL_ADVISORY = 4;
  localparam int CTRL_VOL_IN_TOL = 5;
  localparam int CTRL_DISP_VAR = 6;
  localparam int CTRL_NOALM_LOW = 7;
  localparam int CTRL_NOERR_LOW = 8;
  localparam int CTRL_DISPENSING = 9;
  localparam int CTRL_UNIT_LO = 10;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

  // Status register fields
  localparam int ST_READY = 0;
  localparam int ST_NOALM = 1;
  localparam int ST_NOERR = 2;
  localparam int ST_INPROC = 3;
  localparam int ST_VOLOK = 4;
  localparam int ST_PURGE = 5;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  typedef enum logic [1:0] {
    UNIT_GAL_US = 2'b00,
    UNIT_GAL_UK = 2'b01,
    UNIT_LITER = 2'b10
  } dso_unit_e;

  typedef enum logic [0:0] {
    JOB_IDLE = 1'b0,
    JOB_RUN = 1'b1
  } dso_job_e;

  localparam logic [7:0] VER_TOP = 8'h00;
  localparam dso_long_t PURGE_RST = 32'h0000_0000;
  localparam logic [2:0] SYNC_RST = 3'h0;

  // Status outputs travel together
  typedef struct packed {
    logic ready;
    logic noAlarm;
    logic noError;
    logic inProcess;
    logic volumeOk;
    logic purgeReq;
  } dso_status_s;
endpackage

// ### rtl/dso_dispenser_status.sv
`timescale 1ns/1ps
// Summary of operation
// - Ready is low after reset and high only while active with no fluid plate alarm; deviations are ignored.
// - On the comm gateway variant no-alarm is high whenever no system alarm is present.
// - On the comm gateway variant no-error is high only with no alarm, deviation or advisory.
// - On the discrete gateway variant a setting picks high or low polarity for no-alarm and no-error.
// - Dispense-in-process is low after reset and high from job start until job end.
// - Volume-OK is high only after a completed job in tolerance while the job-start strobe is still high.
// - After reset purge-request is high if a purge interval is configured, else low.
// - Any dispensing clears purge-request and reloads the purge timer.
// - Purge-request goes high when the purge timer expires and holds until dispensing.
// - The version word holds major, minor, build in bytes 0 to 2 and zero on top.
// - Volume unit codes are 0 for US gallons, 1 for imperial gallons and 2 for liters.
// - Short unsigned values are 12 bits and long unsigned values are 32 bits.
module dso_dispenser_status
  import dso_pkg::*;
#(
  parameter logic [7:0] VER_MAJOR = 8'h01, // Arbitrary value
  parameter logic [7:0] VER_MINOR = 8'h00, // Arbitrary value
  parameter logic [7:0] VER_BUILD = 8'h00, // Arbitrary value
  parameter dso_long_t PURGE_INTERVAL = 32'h0000_0000 // Cycles; zero means no purge interval
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Controller pins
  input wire logic styleStrobe,
  input wire logic dispenseComplete,
  // Status pins
  output dso_status_s status
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [2:0] strobeSync;
    logic [2:0] doneSync;
    logic [CTRL_W-1:0] ctrl;
    dso_long_t purgeLoad;
    dso_long_t purgeCnt;
    logic purgeInit;
    dso_job_e job;
    logic jobDone;
    dso_status_s st;
    logic ack;
    logic [31:0] rdat;
  } dso_state_s;

  // Release stages run on the raw reset, so they live outside the state record
  logic [1:0] rstSync_q;
  // Power-up status: clean control word means no alarm and no error; purge asked for when an interval is set
  localparam dso_status_s ST_RST = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, PURGE_INTERVAL != PURGE_RST};
  dso_state_s s_q;
  dso_state_s s_d;
  logic rstLocal_b;
  logic strobeRise;
  logic doneRise;
  logic wbReq;
  logic wbWrite;
  logic dispensing;
  logic rawNoAlm;
  logic rawNoErr;
  dso_long_t versionWord;
  dso_status_s stNext;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  // Two-stage release keeps the async reset from ending mid-cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstLocal_b = rstSync_q[1];

  // ==========================================================================
  // Combinational helpers
  // ==========================================================================
  // Edge detect reads only the second and third synchroniser stages
  assign strobeRise = s_q.strobeSync[1] & ~s_q.strobeSync[2];
  assign doneRise = s_q.doneSync[1] & ~s_q.doneSync[2];
  assign wbReq = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wbWrite = wbReq & wb_we_i;
  // A running job counts as dispensing, as does the software flag
  assign dispensing = (s_q.job == JOB_RUN) | s_q.ctrl[CTRL_DISPENSING];
  assign versionWord = {VER_TOP, VER_BUILD, VER_MINOR, VER_MAJOR};
  assign rawNoAlm = ~s_q.ctrl[CTRL_SYS_ALARM];
  assign rawNoErr = ~(s_q.ctrl[CTRL_SYS_ALARM] | s_q.ctrl[CTRL_DEVIATION]
                   | s_q.ctrl[CTRL_ADVISORY]);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    stNext = s_q.st;
    s_d.strobeSync = {s_q.strobeSync[1:0], styleStrobe};
    s_d.doneSync = {s_q.doneSync[1:0], dispenseComplete};
    s_d.ack = wbReq;

    // Register writes, byte lanes honoured for the low two control bytes and all four purge bytes
    if (wbWrite) begin
      case (wb_adr_i)
        OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            s_d.ctrl[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            s_d.ctrl[CTRL_W-1:8] = wb_dat_i[CTRL_W-1:8];
          end
        end
        OFF_PURGE: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
              s_d.purgeLoad[i*8 +: 8] = wb_dat_i[i*8 +: 8];
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Read data, unmapped addresses read as zero
    s_d.rdat = 32'h0000_0000;
    if (wbReq && !wb_we_i) begin
      case (wb_adr_i)
        OFF_CTRL: s_d.rdat = {{(32-CTRL_W){1'b0}}, s_q.ctrl};
        OFF_STATUS: begin
          s_d.rdat[ST_READY] = s_q.st.ready;
          s_d.rdat[ST_NOALM] = s_q.st.noAlarm;
          s_d.rdat[ST_NOERR] = s_q.st.noError;
          s_d.rdat[ST_INPROC] = s_q.st.inProcess;
          s_d.rdat[ST_VOLOK] = s_q.st.volumeOk;
          s_d.rdat[ST_PURGE] = s_q.st.purgeReq;
        end
        OFF_VERSION: s_d.rdat = versionWord;
        OFF_PURGE: s_d.rdat = s_q.purgeLoad;
        default: s_d.rdat = 32'h0000_0000;
      endcase
    end

    // Job tracking
    case (s_q.job)
      JOB_IDLE: begin
        if (strobeRise) begin
          s_d.job = JOB_RUN;
          s_d.jobDone = 1'b0;
        end
      end
      JOB_RUN: begin
        if (doneRise) begin
          s_d.job = JOB_IDLE;
          s_d.jobDone = 1'b1;
        end
      end
      default: s_d.job = JOB_IDLE;
    endcase

    // Purge timer; first cycle after reset loads the interval
    if (!s_q.purgeInit) begin
      s_d.purgeInit = 1'b1;
      s_d.purgeCnt = s_q.purgeLoad;
      stNext.purgeReq = (s_q.purgeLoad != PURGE_RST);
    end else if (dispensing) begin
      s_d.purgeCnt = s_q.purgeLoad;
      stNext.purgeReq = 1'b0;
    end else if (s_q.purgeCnt != PURGE_RST) begin
      s_d.purgeCnt = s_q.purgeCnt - 32'h0000_0001;
      if (s_q.purgeCnt == 32'h0000_0001) begin
        stNext.purgeReq = 1'b1;
      end
    end

    // Registered status outputs
    stNext.ready = s_q.ctrl[CTRL_ACTIVE] & ~s_q.ctrl[CTRL_FP_ALARM];
    stNext.inProcess = (s_d.job == JOB_RUN);
    stNext.volumeOk = s_d.jobDone & s_q.ctrl[CTRL_VOL_IN_TOL] & s_q.strobeSync[1];
    // Polarity choice only exists on the discrete variant
    if (s_q.ctrl[CTRL_DISP_VAR]) begin
      stNext.noAlarm = rawNoAlm ^ s_q.ctrl[CTRL_NOALM_LOW];
      stNext.noError = rawNoErr ^ s_q.ctrl[CTRL_NOERR_LOW];
    end else begin
      stNext.noAlarm = rawNoAlm;
      stNext.noError = rawNoErr;
    end
    s_d.st = stNext;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Async reset loads constants only; the reset loads the purge interval default
  always_ff @(posedge clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      s_q.strobeSync <= SYNC_RST;
      s_q.doneSync <= SYNC_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.purgeLoad <= PURGE_INTERVAL;
      s_q.purgeCnt <= PURGE_RST;
      s_q.purgeInit <= 1'b0;
      s_q.job <= JOB_IDLE;
      s_q.jobDone <= 1'b0;
      s_q.st <= ST_RST;
      s_q.ack <= 1'b0;
      s_q.rdat <= 32'h0000_0000;
    end else begin
      s_q.strobeSync <= s_d.strobeSync;
      s_q.doneSync <= s_d.doneSync;
      s_q.ctrl <= s_d.ctrl;
      s_q.purgeLoad <= s_d.purgeLoad;
      s_q.purgeCnt <= s_d.purgeCnt;
      s_q.purgeInit <= s_d.purgeInit;
      s_q.job <= s_d.job;
      s_q.jobDone <= s_d.jobDone;
      s_q.st <= s_d.st;
      s_q.ack <= s_d.ack;
      s_q.rdat <= s_d.rdat;
    end
  end

  assign status = s_q.st;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  ready_follows_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    ##1 s_q.st.ready == $past(s_q.ctrl[CTRL_ACTIVE] & ~s_q.ctrl[CTRL_FP_ALARM]))
    else $error("ready mismatch");
  noalarm_cgm_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (!s_q.ctrl[CTRL_DISP_VAR] && !s_q.ctrl[CTRL_SYS_ALARM]) ##1 $stable(s_q.ctrl) |-> s_q.st.noAlarm)
    else $error("no-alarm low without alarm");
  noerror_cgm_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (!s_q.ctrl[CTRL_DISP_VAR] && s_q.ctrl[CTRL_DEVIATION]) |=> !s_q.st.noError)
    else $error("no-error high with deviation");
  polarity_dgm_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.ctrl[CTRL_DISP_VAR] && s_q.ctrl[CTRL_NOALM_LOW] && !s_q.ctrl[CTRL_SYS_ALARM]) |=> !s_q.st.noAlarm)
    else $error("inverted no-alarm wrong");
  inproc_start_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (strobeRise && s_q.job == JOB_IDLE) |=> s_q.st.inProcess)
    else $error("in-process not set on start");
  volok_strobe_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    s_q.st.volumeOk |-> $past(s_q.strobeSync[1]) && $past(s_q.ctrl[CTRL_VOL_IN_TOL]))
    else $error("volume ok without cause");
  purge_clear_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.purgeInit && dispensing) |=> !s_q.st.purgeReq && s_q.purgeCnt == $past(s_q.purgeLoad))
    else $error("dispensing did not clear purge");
  purge_expire_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.purgeInit && !dispensing && s_q.purgeCnt == 32'h0000_0001) |=> s_q.st.purgeReq)
    else $error("purge not raised on expiry");

  // Job tracking: in-process covers the whole job and nothing else
  inproc_end_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (doneRise && s_q.job == JOB_RUN) |=> !s_q.st.inProcess)
    else $error("in-process not cleared on job end");
  inproc_hold_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.job == JOB_RUN && !doneRise) |=> s_q.st.inProcess)
    else $error("in-process dropped inside a job");
  idle_quiet_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.job == JOB_IDLE && !strobeRise) |=> !s_q.st.inProcess)
    else $error("in-process without a start edge");
  restart_ignored_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.job == JOB_RUN && strobeRise && !doneRise) |=> s_q.job == JOB_RUN && !s_q.jobDone)
    else $error("start edge inside a job changed state");

  // Volume-OK needs a finished job, tolerance and a high strobe together
  volok_raise_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (doneRise && s_q.job == JOB_RUN && s_q.ctrl[CTRL_VOL_IN_TOL] && s_q.strobeSync[1]) |=> s_q.st.volumeOk)
    else $error("volume ok not raised on good job");
  volok_tol_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    !s_q.ctrl[CTRL_VOL_IN_TOL] |=> !s_q.st.volumeOk)
    else $error("volume ok outside tolerance");
  volok_drop_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    !s_q.strobeSync[1] |=> !s_q.st.volumeOk)
    else $error("volume ok with strobe low");
  volok_idle_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    s_q.st.volumeOk |-> !s_q.st.inProcess)
    else $error("volume ok inside a job");

  // Purge timer: power-up value, countdown and sticky request
  purge_init_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    !s_q.purgeInit |=> s_q.st.purgeReq == ($past(s_q.purgeLoad) != PURGE_RST))
    else $error("purge power-up value wrong");
  purge_hold_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.purgeInit && !dispensing && s_q.st.purgeReq) |=> s_q.st.purgeReq)
    else $error("purge request dropped without dispensing");
  purge_count_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.purgeInit && !dispensing && s_q.purgeCnt != PURGE_RST)
    |=> s_q.purgeCnt == $past(s_q.purgeCnt) - 32'h0000_0001)
    else $error("purge timer did not count");
  purge_early_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.purgeInit && !dispensing && !s_q.st.purgeReq && s_q.purgeCnt != 32'h0000_0001) |=> !s_q.st.purgeReq)
    else $error("purge raised before expiry");

  // Alarm, error and polarity outputs
  noalarm_set_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (!s_q.ctrl[CTRL_DISP_VAR] && s_q.ctrl[CTRL_SYS_ALARM]) |=> !s_q.st.noAlarm)
    else $error("no-alarm high with alarm");
  noerror_alarm_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (!s_q.ctrl[CTRL_DISP_VAR] && (s_q.ctrl[CTRL_SYS_ALARM] || s_q.ctrl[CTRL_ADVISORY])) |=> !s_q.st.noError)
    else $error("no-error high with alarm or advisory");
  noerror_clean_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (!s_q.ctrl[CTRL_DISP_VAR] && s_q.ctrl[CTRL_ADVISORY:CTRL_SYS_ALARM] == 3'h0) |=> s_q.st.noError)
    else $error("no-error low with clean system");
  polarity_err_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.ctrl[CTRL_DISP_VAR] && s_q.ctrl[CTRL_NOERR_LOW] && s_q.ctrl[CTRL_ADVISORY:CTRL_SYS_ALARM] == 3'h0)
    |=> !s_q.st.noError)
    else $error("inverted no-error wrong");
  polarity_high_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.ctrl[CTRL_DISP_VAR] && !s_q.ctrl[CTRL_NOALM_LOW] && !s_q.ctrl[CTRL_SYS_ALARM]) |=> s_q.st.noAlarm)
    else $error("active-high no-alarm wrong");
  ready_dev_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (s_q.ctrl[CTRL_ACTIVE] && !s_q.ctrl[CTRL_FP_ALARM] && s_q.ctrl[CTRL_DEVIATION]) |=> s_q.st.ready)
    else $error("deviation dropped ready");
  ready_alarm_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    s_q.ctrl[CTRL_FP_ALARM] |=> !s_q.st.ready)
    else $error("ready high with fluid plate alarm");

  // Register bus answer
  ack_answer_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (wb_cyc_i && wb_stb_i && !s_q.ack) |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  rdat_idle_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside acknowledge");
  version_top_a: assert property (@(posedge clk) disable iff (!rstLocal_b)
    (wbReq && !wb_we_i && wb_adr_i == OFF_VERSION) |=> wb_dat_o[31:24] == VER_TOP && wb_dat_o[7:0] == VER_MAJOR)
    else $error("version word layout wrong");
endmodule // dso_dispenser_status

// ### testbench/dso_ctrl_model.sv
`timescale 1ns/1ps
// ============================================================
// Automation controller model
// ============================================================
module dso_ctrl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Commands from the bench
  input wire logic startReq,
  input wire logic endReq,
  input wire logic dropReq,
  // Pins toward the dispenser
  output logic styleStrobe,
  output logic dispenseComplete
);
  // Pins move right after the edge; complete drops at start so each end is a fresh rise
  // Both pins rest low through reset, so the first job is a clean rise
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      styleStrobe <= 1'b0;
      dispenseComplete <= 1'b0;
    end else begin
      if (startReq) begin
        styleStrobe <= 1'b1;
        dispenseComplete <= 1'b0;
      end
      if (endReq) begin
        dispenseComplete <= 1'b1;
      end
      if (dropReq) begin
        styleStrobe <= 1'b0;
      end
    end
  end
endmodule // dso_ctrl_model

// ### testbench/tb_dso_dispenser_status.sv
`timescale 1ns/1ps
module tb_dso_dispenser_status;
  import dso_pkg::*;
  localparam int PURGE_CYC = 20;
  logic clk, rst_b, cyc, stb, we, ack, styleStrobe, dispenseComplete;
  logic [ADDR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] cmd;
  dso_status_s status;
  int miscompares = 0;
  int n_compared = 0;
  logic [11:0] ctrlTab [8] = '{12'h001, 12'h003, 12'h009, 12'h011, 12'h005, 12'h1c0, 12'h040, 12'h1c4};
  logic [5:0] expTab [8] = '{6'h38, 6'h00, 6'h30, 6'h10, 6'h00, 6'h00, 6'h18, 6'h18};
  logic [5:0] maskTab [8] = '{6'h38, 6'h20, 6'h38, 6'h18, 6'h18, 6'h18, 6'h18, 6'h18};

  // ============================================================
  // Design and controller model
  // ============================================================
  dso_dispenser_status #(.VER_MAJOR(8'h3c), .VER_MINOR(8'h5a), .VER_BUILD(8'h21),
    .PURGE_INTERVAL(32'h0000_0014)) dso_dispenser_status_inst (.clk(clk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .styleStrobe(styleStrobe), .dispenseComplete(dispenseComplete),
    .status(status));
  dso_ctrl_model dso_ctrl_model_inst (.clk(clk), .rst_b(rst_b), .startReq(cmd[0]), .endReq(cmd[1]), .dropReq(cmd[2]),
    .styleStrobe(styleStrobe), .dispenseComplete(dispenseComplete));

  // ============================================================
  // Tasks
  // ============================================================
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic cycle held until ack, then one idle cycle
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack});
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  // Status sampled mid-cycle, where it has settled
  task automatic st(input logic [5:0] exp, input logic [5:0] mask);
    @(negedge clk);
    chk("status", {26'h0, exp & mask}, {26'h0, status & mask});
  endtask

  // One-cycle command to the model, then time for the pin synchronisers
  task automatic ctl(input logic [2:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 3'h0;
    repeat (6) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ============================================================
  // Clock, watchdog and tests
  // ============================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h0;
    cmd = 3'h0;
    repeat (8) @(posedge clk);
    st(6'h19, 6'h3f);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    st(6'h19, 6'h3f);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk("status reg", 32'h26, q);
    xfer(1'b0, OFF_VERSION, 32'h0);
    chk("version", 32'h0021_5a3c, q);
    xfer(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    // Alarm, deviation, advisory and polarity table
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, OFF_CTRL, {20'h0, ctrlTab[i]});
      st(expTab[i], maskTab[i]);
    end
    for (int u = 0; u < 3; u++) begin
      xfer(1'b1, OFF_CTRL, {20'h0, u[1:0], 10'h0});
      xfer(1'b0, OFF_CTRL, 32'h0);
      chk("unit", {20'h0, u[1:0], 10'h0}, q & 32'h0000_0c00);
    end
    chk("unit enum", 32'h24, {26'h0, UNIT_LITER, UNIT_GAL_UK, UNIT_GAL_US});
    xfer(1'b1, OFF_PURGE, 32'h8765_4321);
    xfer(1'b0, OFF_PURGE, 32'h0);
    chk("purge reg", 32'h8765_4321, q);
    chk("short width", 32'd12, $bits(dso_short_t));
    xfer(1'b1, OFF_PURGE, 32'h0000_0014);
    // Job in tolerance
    xfer(1'b1, OFF_CTRL, 32'h21);
    ctl(3'b001);
    st(6'h3c, 6'h3f);
    ctl(3'b010);
    st(6'h3a, 6'h3f);
    repeat (PURGE_CYC + 6) @(posedge clk);
    st(6'h3b, 6'h3f);
    xfer(1'b1, OFF_CTRL, 32'h221);
    st(6'h3a, 6'h3f);
    ctl(3'b100);
    st(6'h38, 6'h3f);
    // Job outside tolerance gives no volume-OK
    xfer(1'b1, OFF_CTRL, 32'h1);
    ctl(3'b001);
    ctl(3'b010);
    st(6'h00, 6'h06);
    // Reset after the job has ended returns every status output to its power-up value
    @(posedge clk);
    rst_b <= 1'b0;
    st(6'h19, 6'h3f);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    st(6'h19, 6'h3f);
    finish_test();
  end
endmodule // tb_dso_dispenser_status
